/* File: dcl_pkg.sv */
// Shared constants and types for the DDR2 command, calibration and termination logic
// How it works
// - Drive-high: data and true strobes high, complement low; drive-low reversed.
// - Field 000 exit, 001 high, 010 low, 100 adjust, 111 default.
// - Adjust command plus four-bit code on all lanes moves all drivers together.
// - Codes 0001/0010 step pull-up up/down; 0100/1000 step pull-down.
// - 0101, 0110, 1001, 1010 step both drivers; other codes reserved.
// - Each setting stays in sixteen steps; moves past a limit are ignored.
// - Code taken in fixed bit-time order at additive plus column latency minus one.
// - Drive modes turn outputs on, and off after exit, a fixed delay later.
// - Termination pin controls termination, forced off during self-refresh.
// - Chip select, row strobe, write enable low, column high: precharge.
// - Precharge closes all banks with the auto-precharge bit, else one bank.
// - Deselect ignores control inputs; no-operation idles; work in flight completes.
// - Chip select and row strobe low, others high: activate one of four banks.
// - Chip select and column strobe low, write enable high: burst read.
// - Chip select, column strobe and write enable low: burst write.
// - Column commands wait additive latency; read latency AL+CL, write one less.
// - Bank bits 01 select first extended register; address 7 to 9 calibrate.
package dcl_pkg;
    localparam int DQ_W = 16;
    localparam int AP_BIT = 10;
    localparam int BL_LSB = 0;
    localparam int CL_LSB = 4;
    localparam int AL_LSB = 3;
    localparam int OCD_LSB = 7;
    localparam int AL_MAX = 7;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR1 = 2'h1;
    localparam logic [1:0] BA_EMR3 = 2'h3;
    localparam logic [2:0] OCD_EXIT = 3'h0;
    localparam logic [2:0] OCD_HIGH = 3'h1;
    localparam logic [2:0] OCD_LOW = 3'h2;
    localparam logic [2:0] OCD_ADJ = 3'h4;
    localparam logic [2:0] OCD_DFLT = 3'h7;
    localparam logic [3:0] STEP_MIN = 4'h0;
    localparam logic [3:0] STEP_MAX = 4'hf;
    localparam logic [3:0] STEP_RST = 4'h8;
    localparam int OIT_NS = 24;
    localparam int LINK_NS = 12;
    localparam int OIT_CYC = (OIT_NS + LINK_NS - 1) / LINK_NS;

    // Command and address pins sampled on the link clock
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [12:0] addr;
    } dcl_pins_t;

    // Posted column command
    typedef struct packed {
        logic vld;
        logic wr;
        logic [1:0] ba;
    } dcl_col_t;

    // Calibration drive levels
    typedef struct packed {
        logic oe;
        logic dq;
        logic dqs;
        logic dqs_n;
    } dcl_drv_t;

    localparam dcl_drv_t DRV_OFF = 4'h0;
    localparam dcl_drv_t DRV_HIGH = 4'he;
    localparam dcl_drv_t DRV_LOW = 4'h9;

    typedef enum logic [2:0] {
        C_DESEL = 3'h0,
        C_NOP = 3'h1,
        C_ACT = 3'h2,
        C_RD = 3'h3,
        C_WR = 3'h4,
        C_PRE = 3'h5,
        C_MRS = 3'h6,
        C_REF = 3'h7
    } dcl_cmd_t;

    typedef enum logic [1:0] {
        OM_OFF = 2'h0,
        OM_HIGH = 2'h1,
        OM_LOW = 2'h2,
        OM_ADJ = 2'h3
    } dcl_ocd_t;
endpackage

/* File: dcl_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/100ps
module dcl_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        meta_r <= d;
        q <= meta_r;
    end
endmodule

/* File: dcl_ddr2_cmd.sv */
// DDR2 device command decode, driver calibration and termination logic
`timescale 1ns/100ps
module dcl_ddr2_cmd #(
    parameter int OIT_CYC = dcl_pkg::OIT_CYC,
    parameter logic [3:0] STEP_RST = dcl_pkg::STEP_RST
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ck,
    input wire dcl_pkg::dcl_pins_t pins,
    input wire logic odt,
    input wire logic self_ref,
    input wire logic [dcl_pkg::DQ_W-1:0] dq_rise,
    input wire logic [dcl_pkg::DQ_W-1:0] dq_fall,
    output dcl_pkg::dcl_drv_t drv_r,
    output logic odt_en_r,
    output logic [3:0] bank_open_r,
    output dcl_pkg::dcl_col_t col_r,
    output logic [3:0] rd_lat_r,
    output logic [3:0] wr_lat_r,
    output dcl_pkg::dcl_ocd_t ocd_mode_r,
    output logic [3:0] pu_step_r,
    output logic [3:0] pd_step_r,
    output logic proto_err_r,
    output logic [3:0] sys_bank_open_r,
    output logic sys_cal_open_r,
    output logic [3:0] sys_pu_r,
    output logic [3:0] sys_pd_r
);
    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Command decode from the sampled pins
    function automatic dcl_pkg::dcl_cmd_t dec_cmd(input dcl_pkg::dcl_pins_t p);
        dcl_pkg::dcl_cmd_t c;
        c = dcl_pkg::C_NOP;
        if (!p.cke || p.cs_n) begin
            c = dcl_pkg::C_DESEL;
        end else begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h3: c = dcl_pkg::C_ACT;
                3'h5: c = dcl_pkg::C_RD;
                3'h4: c = dcl_pkg::C_WR;
                3'h2: c = dcl_pkg::C_PRE;
                3'h0: c = dcl_pkg::C_MRS;
                3'h1: c = dcl_pkg::C_REF;
                default: c = dcl_pkg::C_NOP;
            endcase
        end
        return c;
    endfunction

    // Burst code to {pd_dec, pd_inc, pu_dec, pu_inc}
    function automatic logic [3:0] dec_burst(input logic [3:0] code);
        logic [3:0] s;
        s = code;
        // Reserved codes act as no change
        if ((code[0] && code[1]) || (code[2] && code[3])) begin
            s = 4'h0;
        end
        return s;
    endfunction

    // Saturating one-step move of a driver setting
    function automatic logic [3:0] step(input logic [3:0] v, input logic up, input logic dn);
        logic [3:0] r;
        r = v;
        if (up && v != dcl_pkg::STEP_MAX) begin
            r = v + 4'h1;
        end else if (dn && v != dcl_pkg::STEP_MIN) begin
            r = v - 4'h1;
        end
        return r;
    endfunction

    // Binary to gray, so single steps cross safely
    function automatic logic [3:0] to_gray(input logic [3:0] v);
        return v ^ (v >> 1);
    endfunction

    // Gray back to binary
    function automatic logic [3:0] from_gray(input logic [3:0] g);
        logic [3:0] b;
        b[3] = g[3];
        b[2] = b[3] ^ g[2];
        b[1] = b[2] ^ g[1];
        b[0] = b[1] ^ g[0];
        return b;
    endfunction

    // ---------------------------------------------------------------
    // Link-side reset and decode
    // ---------------------------------------------------------------
    localparam logic [3:0] OIT_LD = 4'(OIT_CYC);

    logic rst_lk;
    dcl_pkg::dcl_cmd_t cmd;
    logic mr_wr;
    logic emr1_wr;
    logic [2:0] ocd_f;
    logic [2:0] bl_r;
    logic [2:0] cl_r;
    logic [2:0] al_r;
    logic [3:0] wl;

    // Reset brought onto the link clock
    dcl_sync #(.W(1)) u_rst_sync (
        .clk(ck),
        .d(rst),
        .q(rst_lk)
    );

    // Command and register select
    assign cmd = dec_cmd(pins);
    assign mr_wr = (cmd == dcl_pkg::C_MRS) && (pins.ba == dcl_pkg::BA_MR);
    assign emr1_wr = (cmd == dcl_pkg::C_MRS) && (pins.ba == dcl_pkg::BA_EMR1);
    assign ocd_f = pins.addr[dcl_pkg::OCD_LSB +: 3];
    assign wl = {1'b0, al_r} + {1'b0, cl_r} - 4'h1;

    // Base and first extended register fields
    always_ff @(posedge ck) begin
        if (rst_lk) begin
            bl_r <= dcl_pkg::BL_FOUR;
            cl_r <= dcl_pkg::CL_RST;
            al_r <= 3'h0;
        end else if (mr_wr) begin
            bl_r <= pins.addr[dcl_pkg::BL_LSB +: 3];
            cl_r <= pins.addr[dcl_pkg::CL_LSB +: 3];
        end else if (emr1_wr) begin
            al_r <= pins.addr[dcl_pkg::AL_LSB +: 3];
        end
    end

    always_ff @(posedge ck) begin
        if (rst_lk) begin
            rd_lat_r <= 4'h0;
            wr_lat_r <= 4'h0;
        end else begin
            rd_lat_r <= {1'b0, al_r} + {1'b0, cl_r};
            wr_lat_r <= wl;
        end
    end

    // ---------------------------------------------------------------
    // Bank state
    // ---------------------------------------------------------------

    // Open-bank tracking; idle cycles leave it alone
    always_ff @(posedge ck) begin
        if (rst_lk) begin
            bank_open_r <= 4'h0;
        end else if (cmd == dcl_pkg::C_ACT) begin
            bank_open_r[pins.ba] <= 1'b1;
        end else if (cmd == dcl_pkg::C_PRE && pins.addr[dcl_pkg::AP_BIT]) begin
            bank_open_r <= 4'h0;
        end else if (cmd == dcl_pkg::C_PRE) begin
            bank_open_r[pins.ba] <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Posted column commands
    // ---------------------------------------------------------------
    dcl_pkg::dcl_col_t col_now;
    dcl_pkg::dcl_col_t pipe_r [0:dcl_pkg::AL_MAX-1];

    assign col_now = {(cmd == dcl_pkg::C_RD) || (cmd == dcl_pkg::C_WR),
                      cmd == dcl_pkg::C_WR, pins.ba};

    // Delay line holding accepted column commands
    always_ff @(posedge ck) begin
        if (rst_lk) begin
            for (int i = 0; i < dcl_pkg::AL_MAX; i++) begin
                pipe_r[i] <= '0;
            end
        end else begin
            pipe_r[0] <= col_now;
            for (int i = 1; i < dcl_pkg::AL_MAX; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end

    always_ff @(posedge ck) begin
        if (rst_lk) begin
            col_r <= '0;
        end else if (al_r == 3'h0) begin
            col_r <= col_now;
        end else begin
            col_r <= pipe_r[al_r - 3'h1];
        end
    end

    // ---------------------------------------------------------------
    // Calibration mode and sequencing
    // ---------------------------------------------------------------
    logic cal_open_r;

    always_ff @(posedge ck) begin
        if (rst_lk) begin
            ocd_mode_r <= dcl_pkg::OM_OFF;
        end else if (emr1_wr) begin
            case (ocd_f)
                dcl_pkg::OCD_EXIT: ocd_mode_r <= dcl_pkg::OM_OFF;
                dcl_pkg::OCD_HIGH: ocd_mode_r <= dcl_pkg::OM_HIGH;
                dcl_pkg::OCD_LOW: ocd_mode_r <= dcl_pkg::OM_LOW;
                dcl_pkg::OCD_ADJ: ocd_mode_r <= dcl_pkg::OM_ADJ;
                default: ocd_mode_r <= ocd_mode_r;
            endcase
        end
    end

    always_ff @(posedge ck) begin
        if (rst_lk) begin
            cal_open_r <= 1'b0;
            proto_err_r <= 1'b0;
        end else begin
            proto_err_r <= (cal_open_r && cmd != dcl_pkg::C_DESEL && cmd != dcl_pkg::C_NOP
                            && !(emr1_wr && ocd_f == dcl_pkg::OCD_EXIT))
                           || (emr1_wr && ocd_f == dcl_pkg::OCD_ADJ
                               && bl_r != dcl_pkg::BL_FOUR)
                           || (cmd == dcl_pkg::C_MRS && pins.ba == dcl_pkg::BA_EMR3
                               && pins.addr != 13'h0);
            if (emr1_wr) begin
                cal_open_r <= (ocd_f != dcl_pkg::OCD_EXIT);
            end
        end
    end

    // ---------------------------------------------------------------
    // Adjustment burst and driver steps
    // ---------------------------------------------------------------
    logic adj_busy_r;
    logic adj_half_r;
    logic [3:0] adj_cnt_r;
    logic [1:0] dt01_r;
    logic [3:0] bc;
    logic restore_r;
    logic [3:0] pu_g_r;
    logic [3:0] pd_g_r;

    // Capture bit-times 0..1 at write latency
    always_ff @(posedge ck) begin
        if (rst_lk) begin
            adj_busy_r <= 1'b0;
            adj_half_r <= 1'b0;
            adj_cnt_r <= 4'h0;
            dt01_r <= 2'h0;
        end else begin
            adj_half_r <= 1'b0;
            if (emr1_wr && ocd_f == dcl_pkg::OCD_ADJ) begin
                adj_busy_r <= 1'b1;
                adj_cnt_r <= wl;
            end else if (adj_busy_r && adj_cnt_r > 4'h1) begin
                adj_cnt_r <= adj_cnt_r - 4'h1;
            end else if (adj_busy_r) begin
                adj_busy_r <= 1'b0;
                adj_half_r <= 1'b1;
                dt01_r <= {dq_rise[0], dq_fall[0]};
            end
        end
    end

    // Lane zero code, applied to all drivers
    assign bc = dec_burst({dt01_r, dq_rise[0], dq_fall[0]});

    always_ff @(posedge ck) begin
        if (rst_lk) begin
            pu_step_r <= STEP_RST;
            pd_step_r <= STEP_RST;
            restore_r <= 1'b0;
        end else if (emr1_wr && ocd_f == dcl_pkg::OCD_DFLT) begin
            restore_r <= 1'b1;
        end else if (restore_r) begin
            // Walk to default one step a cycle
            pu_step_r <= step(pu_step_r, pu_step_r < STEP_RST, pu_step_r > STEP_RST);
            pd_step_r <= step(pd_step_r, pd_step_r < STEP_RST, pd_step_r > STEP_RST);
            restore_r <= (pu_step_r != STEP_RST) || (pd_step_r != STEP_RST);
        end else if (adj_half_r) begin
            pu_step_r <= step(pu_step_r, bc[0], bc[1]);
            pd_step_r <= step(pd_step_r, bc[2], bc[3]);
        end
    end

    // Gray copies of settings for the system side
    always_ff @(posedge ck) begin
        if (rst_lk) begin
            pu_g_r <= to_gray(STEP_RST);
            pd_g_r <= to_gray(STEP_RST);
        end else begin
            pu_g_r <= to_gray(pu_step_r);
            pd_g_r <= to_gray(pd_step_r);
        end
    end

    // ---------------------------------------------------------------
    // Drive modes and termination
    // ---------------------------------------------------------------
    dcl_pkg::dcl_drv_t drv_sel;
    dcl_pkg::dcl_drv_t pend_r;
    logic [3:0] oit_cnt_r;
    logic drv_load;

    always_comb begin
        case (ocd_f)
            dcl_pkg::OCD_HIGH: drv_sel = dcl_pkg::DRV_HIGH;
            dcl_pkg::OCD_LOW: drv_sel = dcl_pkg::DRV_LOW;
            default: drv_sel = dcl_pkg::DRV_OFF;
        endcase
    end

    assign drv_load = emr1_wr && (ocd_f == dcl_pkg::OCD_HIGH || ocd_f == dcl_pkg::OCD_LOW
                                  || ocd_f == dcl_pkg::OCD_EXIT);

    // Apply drive change after fixed delay
    always_ff @(posedge ck) begin
        if (rst_lk) begin
            pend_r <= dcl_pkg::DRV_OFF;
            oit_cnt_r <= 4'h0;
            drv_r <= dcl_pkg::DRV_OFF;
        end else if (drv_load) begin
            pend_r <= drv_sel;
            oit_cnt_r <= OIT_LD;
        end else if (oit_cnt_r > 4'h1) begin
            oit_cnt_r <= oit_cnt_r - 4'h1;
        end else if (oit_cnt_r == 4'h1) begin
            drv_r <= pend_r;
            oit_cnt_r <= 4'h0;
        end
    end

    always_ff @(posedge ck) begin
        if (rst_lk) begin
            odt_en_r <= 1'b0;
        end else begin
            odt_en_r <= odt && !self_ref;
        end
    end

    // ---------------------------------------------------------------
    // System clock side status
    // ---------------------------------------------------------------
    logic [12:0] xs;

    // Levels and gray words cross by two flops
    dcl_sync #(.W(13)) u_xsync (
        .clk(clk),
        .d({cal_open_r, bank_open_r, pu_g_r, pd_g_r}),
        .q(xs)
    );

    // Registered status in the system domain
    always_ff @(posedge clk) begin
        if (rst) begin
            sys_cal_open_r <= 1'b0;
            sys_bank_open_r <= 4'h0;
            sys_pu_r <= STEP_RST;
            sys_pd_r <= STEP_RST;
        end else begin
            sys_cal_open_r <= xs[12];
            sys_bank_open_r <= xs[11:8];
            sys_pu_r <= from_gray(xs[7:4]);
            sys_pd_r <= from_gray(xs[3:0]);
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking dcl_cb @(posedge ck);
    endclocking
    default disable iff (rst_lk);

    act_open_a: assert property (cmd == dcl_pkg::C_ACT |=> bank_open_r[$past(pins.ba)])
        else $error("activate did not open bank");
    pre_all_a: assert property (
        cmd == dcl_pkg::C_PRE && pins.addr[dcl_pkg::AP_BIT] |=> bank_open_r == 4'h0)
        else $error("precharge all left a bank open");
    pre_one_a: assert property (
        cmd == dcl_pkg::C_PRE && !pins.addr[dcl_pkg::AP_BIT] |=> !bank_open_r[$past(pins.ba)])
        else $error("precharge did not close bank");
    desel_keep_a: assert property (
        cmd == dcl_pkg::C_DESEL |=> $stable(bank_open_r) && $stable(ocd_mode_r))
        else $error("deselect changed state");
    col_al0_a: assert property (
        cmd == dcl_pkg::C_RD && al_r == 3'h0 |=> col_r.vld && !col_r.wr)
        else $error("read not issued at zero latency");
    col_al2_a: assert property (
        (cmd == dcl_pkg::C_WR && al_r == 3'h2) ##1 $stable(al_r) |-> ##2 col_r.vld && col_r.wr)
        else $error("write not issued after additive latency");
    odt_sr_a: assert property (self_ref |=> !odt_en_r)
        else $error("termination on in self-refresh");
    ocd_high_a: assert property (
        emr1_wr && ocd_f == dcl_pkg::OCD_HIGH |=> ocd_mode_r == dcl_pkg::OM_HIGH)
        else $error("drive-high mode not entered");
    drv_on_a: assert property (
        (emr1_wr && ocd_f == dcl_pkg::OCD_HIGH) ##1 !emr1_wr [*2] |-> ##1 drv_r == dcl_pkg::DRV_HIGH)
        else $error("drive-high outputs not on after delay");
    step_sat_a: assert property (
        adj_half_r && !restore_r && bc[0] && pu_step_r == dcl_pkg::STEP_MAX
        |=> pu_step_r == dcl_pkg::STEP_MAX)
        else $error("pull-up stepped past limit");
    step_up_a: assert property (
        adj_half_r && !restore_r && bc[0] && pu_step_r != dcl_pkg::STEP_MAX
        |=> pu_step_r == $past(pu_step_r) + 4'h1)
        else $error("pull-up did not step up");
    adj_cap_a: assert property (
        (emr1_wr && ocd_f == dcl_pkg::OCD_ADJ && wl == 4'h2) ##1 !emr1_wr [*2] |=> adj_half_r)
        else $error("adjust code not taken at write latency");
    err_seq_a: assert property (cal_open_r && cmd == dcl_pkg::C_ACT |=> proto_err_r)
        else $error("command before calibration exit not flagged");

    act_rd_c: cover property (cmd == dcl_pkg::C_ACT ##[1:8] cmd == dcl_pkg::C_RD);
    adj_apply_c: cover property (adj_half_r && bc != 4'h0);
    drv_high_c: cover property (drv_r == dcl_pkg::DRV_HIGH);
endmodule

/* File: dcl_ctrl_model.sv */
// Memory controller model: command pins and calibration bursts on the link clock
`timescale 1ns/100ps
module dcl_ctrl_model (
    input wire logic ck,
    output dcl_pkg::dcl_pins_t pins,
    output logic [15:0] dq_rise,
    output logic [15:0] dq_fall
);
    // Idle: deselected, data lines parked on opposite levels
    initial begin
        pins = {1'h1, 1'h1, 3'h7, 2'h0, 13'h0};
        dq_rise = 16'h0;
        dq_fall = 16'hffff;
    end

    // One command for one link cycle, then deselect with inverted address
    task automatic issue(input logic cs_n, input logic [2:0] rcw, input logic [1:0] ba,
        input logic [12:0] addr);
        @(posedge ck);
        #1;
        pins = {1'h1, cs_n, rcw, ba, addr};
        @(posedge ck);
        #1;
        pins = {1'h1, 1'h1, ~rcw, ~ba, ~addr};
    endtask

    // Same code on all lanes, bit-time 0 first, at write latency
    task automatic burst(input logic [3:0] code, input int wl);
        repeat (wl - 1) @(posedge ck);
        #1;
        dq_rise = {16{code[3]}};
        dq_fall = {16{code[2]}};
        @(posedge ck);
        #1;
        dq_rise = {16{code[1]}};
        dq_fall = {16{code[0]}};
        @(posedge ck);
        #1;
        dq_rise = ~dq_rise;
        dq_fall = ~dq_fall;
    endtask
endmodule

/* File: test_dcl_ddr2_cmd.sv */
// Self-checking bench for the DDR2 command, calibration and termination logic
`timescale 1ns/100ps
module test_dcl_ddr2_cmd;
    typedef struct packed {
        logic cs_n;
        logic [2:0] rcw;
        logic [1:0] ba;
        logic [12:0] addr;
        logic [3:0] bank;
    } dcl_row_t;
    localparam logic [2:0] MRS = 3'h0;
    localparam logic [2:0] ACT = 3'h3;
    localparam logic [2:0] PRE = 3'h2;
    logic clk, rst, ck, odt, self_ref, ok;
    dcl_pkg::dcl_pins_t pins;
    logic [15:0] dq_rise, dq_fall;
    dcl_pkg::dcl_drv_t drv;
    dcl_pkg::dcl_col_t col;
    dcl_pkg::dcl_ocd_t mode;
    logic odt_en, perr, sys_cal;
    logic [3:0] bank, rd_lat, wr_lat, pu, pd, sys_pu, sys_pd, sys_bank, code, exp_pu, exp_pd;
    int n_mismatch = 0;
    int n_checks = 0;
    // Command rows: chip select, row/column/write strobes, bank, address, banks open after
    dcl_row_t rows [7] = '{{1'h0, ACT, 2'h0, 13'h0, 4'h1}, {1'h0, ACT, 2'h3, 13'h0, 4'h9},
        {1'h0, PRE, 2'h3, 13'h0, 4'h1}, {1'h0, ACT, 2'h2, 13'h0, 4'h5},
        {1'h1, ACT, 2'h1, 13'h0, 4'h5}, {1'h0, 3'h7, 2'h1, 13'h0, 4'h5},
        {1'h0, PRE, 2'h1, 13'h400, 4'h0}};
    logic [3:0] codes [9] = '{4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha, 4'h3, 4'h0};

    dcl_ctrl_model ctl (.ck(ck), .pins(pins), .dq_rise(dq_rise), .dq_fall(dq_fall));
    dcl_ddr2_cmd dut (.clk(clk), .rst(rst), .ck(ck), .pins(pins), .odt(odt),
        .self_ref(self_ref), .dq_rise(dq_rise), .dq_fall(dq_fall), .drv_r(drv),
        .odt_en_r(odt_en), .bank_open_r(bank), .col_r(col), .rd_lat_r(rd_lat),
        .wr_lat_r(wr_lat), .ocd_mode_r(mode), .pu_step_r(pu), .pd_step_r(pd),
        .proto_err_r(perr), .sys_bank_open_r(sys_bank), .sys_cal_open_r(sys_cal),
        .sys_pu_r(sys_pu), .sys_pd_r(sys_pd));

    // Clocks: system 25 ns, link 12 ns with its own phase
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        ck = 1'h0;
        #3;
        forever #6 ck = ~ck;
    end
    // Watchdog
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ck);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Saturating one-step move of a driver setting
    function automatic logic [3:0] step(input logic [3:0] v, input logic up, input logic dn);
        if (up && v != 4'hf) return v + 4'h1;
        if (dn && v != 4'h0) return v - 4'h1;
        return v;
    endfunction
    // Edges from the command edge until the internal issue shows, expected equal to AL
    task automatic col_lat(input logic [2:0] rcw, input logic wr, input logic [3:0] al);
        int n;
        ctl.issue(1'h0, rcw, 2'h0, 13'h0);
        n = 0;
        while (col.vld !== 1'h1 && n < 9) begin
            cyc(1);
            n++;
        end
        check(n[3:0], al, "column delay");
        check(col.wr, wr, "column kind");
        cyc(1);
        check(col.vld, 1'h0, "single pulse");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'h1;
        odt = 1'h0;
        self_ref = 1'h0;
        exp_pu = 4'h8;
        exp_pd = 4'h8;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'h0;
        cyc(4);
        check(pu, 4'h8, "reset step");
        check(drv, dcl_pkg::DRV_OFF, "reset drive");
        check(rd_lat, 4'h3, "reset latency");
        // Init, burst of four; a nonzero third extended write is flagged
        ctl.issue(1'h0, MRS, 2'h3, 13'h0);
        check(perr, 1'h0, "third extended clean");
        ctl.issue(1'h0, MRS, 2'h3, 13'h004);
        check(perr, 1'h1, "third extended address");
        ctl.issue(1'h0, MRS, 2'h0, 13'h032);
        foreach (rows[i]) begin
            ctl.issue(rows[i].cs_n, rows[i].rcw, rows[i].ba, rows[i].addr);
            cyc(2);
            check(bank, rows[i].bank, "bank state");
            if (i == 5) begin
                check(sys_bank, rows[i].bank, "system banks");
            end
        end
        $display("test decode done");
        ctl.issue(1'h0, MRS, 2'h1, 13'h010);
        cyc(1);
        check(rd_lat, 4'h5, "read latency");
        check(wr_lat, 4'h4, "write latency");
        ctl.issue(1'h0, ACT, 2'h0, 13'h0);
        col_lat(3'h5, 1'h0, 4'h2);
        col_lat(3'h4, 1'h1, 4'h2);
        // Close all, latency back, then a read at zero latency after a row delay
        ctl.issue(1'h0, PRE, 2'h0, 13'h400);
        ctl.issue(1'h0, MRS, 2'h1, 13'h0);
        ctl.issue(1'h0, ACT, 2'h0, 13'h0);
        cyc(8);
        col_lat(3'h5, 1'h0, 4'h0);
        ctl.issue(1'h0, PRE, 2'h0, 13'h400);
        $display("test posted done");
        for (int k = 1; k <= 2; k++) begin
            ctl.issue(1'h0, MRS, 2'h1, 13'(k << 7));
            check(drv, dcl_pkg::DRV_OFF, "drive delay");
            cyc(4);
            check(drv, k == 1 ? dcl_pkg::DRV_HIGH : dcl_pkg::DRV_LOW, "drive");
            // Awkward case: a command before the exit is flagged
            if (k == 1) begin
                ctl.issue(1'h0, ACT, 2'h1, 13'h0);
                check(perr, 1'h1, "command before exit");
            end
            ctl.issue(1'h0, MRS, 2'h1, 13'h0);
            check(perr, 1'h0, "exit accepted");
            cyc(4);
            check(drv, dcl_pkg::DRV_OFF, "drive off");
        end
        for (int i = 0; i < 18; i++) begin
            code = i < 9 ? 4'h1 : codes[i - 9];
            ok = code inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha};
            exp_pu = ok ? step(exp_pu, code[0], code[1]) : exp_pu;
            exp_pd = ok ? step(exp_pd, code[2], code[3]) : exp_pd;
            ctl.issue(1'h0, MRS, 2'h1, 13'h200);
            check(mode, dcl_pkg::OM_ADJ, "adjust mode");
            ctl.burst(code, 2);
            check(pu, exp_pu, "pull-up");
            check(pd, exp_pd, "pull-down");
            ctl.issue(1'h0, MRS, 2'h1, 13'h0);
        end
        repeat (8) @(posedge clk);
        #1;
        check(sys_pu, exp_pu, "system pull-up copy");
        check(sys_pd, exp_pd, "system pull-down copy");
        ctl.issue(1'h0, MRS, 2'h1, 13'h380);
        cyc(20);
        check(pu, 4'h8, "default");
        check(pd, 4'h8, "default pull-down");
        check(sys_cal, 1'h1, "system calibration flag");
        ctl.issue(1'h0, MRS, 2'h1, 13'h0);
        $display("test calibration done");
        odt = 1'h1;
        cyc(2);
        check(odt_en, 1'h1, "termination on");
        // Reset in mid-run clears termination and banks, then termination returns
        rst = 1'h1;
        repeat (12) @(posedge clk);
        #1;
        check(odt_en, 1'h0, "reset termination");
        check(bank, 4'h0, "reset banks");
        rst = 1'h0;
        cyc(4);
        check(odt_en, 1'h1, "termination back");
        self_ref = 1'h1;
        cyc(2);
        check(odt_en, 1'h0, "termination off");
        $display("test termination done");
        final_report();
    end
endmodule
